/* File: hw/ifp_pkg.sv */
// package: constants and types for the interrupt fetch phase block
package ifp_pkg;
  localparam int ADDR_W = 15;
  localparam int WORD_W = 16;
  localparam int NUM_SRC = 64;
  localparam int SC_W = 6;
  // internal source select codes, placed ahead of backplane slots
  localparam logic [5:0] SC_POWER_FAIL = 6'h04;
  localparam logic [5:0] SC_PARITY = 6'h05;
  localparam logic [5:0] SC_MEM_PROTECT = 6'h05;
  localparam logic [5:0] SC_DMA_CH1 = 6'h06;
  localparam logic [5:0] SC_DMA_CH2 = 6'h07;
  // memory reference group: opcode bits 14..12 nonzero
  localparam int MRG_OP_MSB = 14;
  localparam int MRG_OP_LSB = 12;
  localparam int MRG_ADDR_MSB = 9;
  localparam int MRG_PAGE_BIT = 10;
  localparam int MRG_IND_BIT = 15;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // phase codes
  typedef enum logic [2:0] {
    IFP_PH_FETCH = 3'b000,
    IFP_PH_INDIRECT = 3'b001,
    IFP_PH_INT_FETCH = 3'b010,
    IFP_PH_INT_READ = 3'b011,
    IFP_PH_EXECUTE = 3'b100
  } ifp_phase_e;
endpackage : ifp_pkg

/* File: hw/ifp_prio.sv */
// priority encoder: lowest select code wins among enabled requesters
module ifp_prio (
  // requests, one bit per select code
  input wire logic [63:0] req,
  input wire logic chain_ok,
  // winner
  output logic any,
  output logic [5:0] code
);
  // break of the chain masks every requester at once
  always_comb begin
    any = 1'b0;
    code = 6'h00;
    for (int i = ifp_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (req[i] && chain_ok) begin
        any = 1'b1;
        code = 6'(i);
      end
    end
  end
endmodule : ifp_prio

/* File: hw/ifp_core.sv */
// interrupt fetch phase sequencer: phase control, pc, address and trap word
module ifp_core (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // backplane and internal requests
  input wire logic [63:0] io_req,
  input wire logic pwr_fail_req,
  input wire logic mem_protect_req,
  input wire logic parity_req,
  input wire logic dma_req,
  input wire logic dma_ch2,
  // processor controls
  input wire logic int_sys_en,
  input wire logic pwr_fail_ctl,
  input wire logic phase_end,
  input wire logic indirect_jump,
  input wire logic subroutine_jump,
  input wire logic exec_done,
  // memory read port
  output logic mem_rd,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // state outputs
  output logic [14:0] pc,
  output logic [14:0] mar,
  output logic [15:0] ir,
  output logic [14:0] scratch1,
  output logic [2:0] phase,
  output logic interrupt_fetch_phase,
  output logic ext_preset_ind,
  output logic [5:0] ack_code
);
  // registered state
  ifp_pkg::ifp_phase_e ph_r, ph_nxt;
  logic [14:0] pc_r;
  logic [14:0] mar_r;
  logic [15:0] ir_r;
  logic [14:0] scr_r;
  logic [5:0] code_r;
  logic [63:0] req_all;
  logic win_any;
  logic [5:0] win_code;

  // entry qualification: level requests, looked at only in cycles where phase_end is high
  wire chain_ok = pwr_fail_ctl;
  wire blocked = indirect_jump | subroutine_jump;
  wire take_int = win_any && int_sys_en && phase_end && !blocked;
  wire is_mrg = |mem_rdata[ifp_pkg::MRG_OP_MSB:ifp_pkg::MRG_OP_LSB];

  // phase decodes shared by the checks below
  wire in_fetch = (ph_r == ifp_pkg::IFP_PH_FETCH);
  wire in_read = (ph_r == ifp_pkg::IFP_PH_INT_READ);
  wire word_in = in_read && mem_ack;

  // operand address from page bit and word offset
  function automatic logic [14:0] opnd_addr(input logic [15:0] w, input logic [14:0] p);
    opnd_addr = w[ifp_pkg::MRG_PAGE_BIT] ? {p[14:10], w[9:0]} : {5'h00, w[9:0]};
  endfunction : opnd_addr

  // merge internal sources into the select-code vector
  always_comb begin
    req_all = io_req;
    if (pwr_fail_req) req_all[ifp_pkg::SC_POWER_FAIL] = 1'b1;
    if (parity_req) req_all[ifp_pkg::SC_PARITY] = 1'b1;
    if (mem_protect_req) req_all[ifp_pkg::SC_MEM_PROTECT] = 1'b1; // shares a code with parity
    if (dma_req) req_all[dma_ch2 ? ifp_pkg::SC_DMA_CH2 : ifp_pkg::SC_DMA_CH1] = 1'b1;
  end

  ifp_prio u_prio (
    .req(req_all),
    .chain_ok(chain_ok),
    .any(win_any),
    .code(win_code)
  );

  // phase sequence
  always_comb begin
    ph_nxt = ph_r;
    case (ph_r)
      ifp_pkg::IFP_PH_FETCH: if (take_int) ph_nxt = ifp_pkg::IFP_PH_INT_FETCH;
      ifp_pkg::IFP_PH_INT_FETCH: ph_nxt = ifp_pkg::IFP_PH_INT_READ;
      ifp_pkg::IFP_PH_INT_READ: if (mem_ack) ph_nxt = ifp_pkg::IFP_PH_EXECUTE;
      ifp_pkg::IFP_PH_EXECUTE: if (exec_done) ph_nxt = ifp_pkg::IFP_PH_FETCH;
      default: ph_nxt = ifp_pkg::IFP_PH_FETCH;
    endcase
  end

  // registers other than the phase move only on entry and on the arrival of the trap word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_r <= ifp_pkg::IFP_PH_FETCH;
      pc_r <= ifp_pkg::PC_RESET;
      mar_r <= ifp_pkg::PC_RESET;
      ir_r <= ifp_pkg::WORD_RESET;
      scr_r <= ifp_pkg::PC_RESET;
      code_r <= 6'h00;
    end else begin
      ph_r <= ph_nxt;
      if (ph_r == ifp_pkg::IFP_PH_FETCH && take_int) begin
        code_r <= win_code; // latch winner so a later request cannot move the trap
        pc_r <= pc_r - 15'h0001;
        mar_r <= {9'h000, win_code};
      end
      if (ph_r == ifp_pkg::IFP_PH_INT_READ && mem_ack) begin
        ir_r <= mem_rdata;
        if (is_mrg) scr_r <= opnd_addr(mem_rdata, mar_r);
      end
    end
  end

  // outputs straight from the state registers; the lamp is the inverse of its control input pwr_fail_ctl
  assign mem_rd = (ph_r == ifp_pkg::IFP_PH_INT_READ);
  assign pc = pc_r;
  assign mar = mar_r;
  assign ir = ir_r;
  assign scratch1 = scr_r;
  assign phase = ph_r;
  assign interrupt_fetch_phase = (ph_r == ifp_pkg::IFP_PH_INT_FETCH) || mem_rd;
  assign ext_preset_ind = !pwr_fail_ctl;
  assign ack_code = code_r;

  // sequencer checks
  AST_ENTRY: assert property (@(posedge sys_clk) disable iff (!rst_b)
    take_int && ph_r == ifp_pkg::IFP_PH_FETCH |=> ph_r == ifp_pkg::IFP_PH_INT_FETCH)
    else $error("request not turned into interrupt fetch");
  AST_DEFER: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ph_r == ifp_pkg::IFP_PH_FETCH && (blocked || !phase_end) |=> ph_r != ifp_pkg::IFP_PH_INT_FETCH)
    else $error("entered during jump or mid phase");
  AST_PC_DEC: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ph_r == ifp_pkg::IFP_PH_FETCH && take_int |=> pc_r == $past(pc_r) - 15'h0001)
    else $error("pc not decremented");
  AST_MAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ph_r == ifp_pkg::IFP_PH_FETCH && take_int |=> mar_r == {9'h000, $past(win_code)})
    else $error("select code not forced");
  AST_IR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ph_r == ifp_pkg::IFP_PH_INT_READ && mem_ack |=> ir_r == $past(mem_rdata))
    else $error("trap word not loaded");
  AST_SCR: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ph_r == ifp_pkg::IFP_PH_INT_READ && mem_ack && is_mrg
    |=> scr_r == opnd_addr($past(mem_rdata), $past(mar_r)))
    else $error("operand address wrong");
  AST_EXEC: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ph_r == ifp_pkg::IFP_PH_INT_READ && mem_ack |=> ph_r == ifp_pkg::IFP_PH_EXECUTE)
    else $error("execute phase not set");
  AST_CHAIN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !pwr_fail_ctl |=> ph_r != ifp_pkg::IFP_PH_INT_FETCH)
    else $error("interrupt with chain broken");
  AST_ENABLE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !int_sys_en |=> ph_r != ifp_pkg::IFP_PH_INT_FETCH)
    else $error("interrupt with system disabled");
  AST_PF_SRC: assert property (@(posedge sys_clk) disable iff (!rst_b)
    take_int && pwr_fail_req && io_req[3:0] == 4'h0 |-> win_code == ifp_pkg::SC_POWER_FAIL)
    else $error("power fail not prioritised");

  // the trap fetch lasts one cycle, then the read is raised at once
  AST_TO_READ: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ph_r == ifp_pkg::IFP_PH_INT_FETCH |=> in_read && mem_rd)
    else $error("trap read not started");

  // a slow memory must not lose the request: it stands until the word arrives
  AST_RD_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    mem_rd && !mem_ack |=> mem_rd)
    else $error("trap read dropped early");

  // the return address moves on entry only, so the interrupted word is kept
  AST_PC_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(in_fetch && take_int) |=> $stable(pc_r))
    else $error("pc moved outside entry");

  // the forced address holds through the read
  AST_MAR_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(in_fetch && take_int) |=> $stable(mar_r))
    else $error("memory address moved outside entry");

  // the instruction register takes the trap word and nothing else
  AST_IR_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !word_in |=> $stable(ir_r))
    else $error("instruction register moved without a word");

  // a word outside the memory reference group leaves scratch one alone
  AST_SCR_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    word_in && !is_mrg |=> $stable(scr_r))
    else $error("scratch one written by a non memory reference word");

  // execute holds until the instruction is done
  AST_EXEC_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ph_r == ifp_pkg::IFP_PH_EXECUTE && !exec_done |=> ph_r == ifp_pkg::IFP_PH_EXECUTE)
    else $error("execute phase left early");

  // parity and memory protect share one code, below dma and above power fail
  AST_PAR_SRC: assert property (@(posedge sys_clk) disable iff (!rst_b)
    take_int && (parity_req || mem_protect_req) && req_all[4:0] == 5'h00
    |-> win_code == ifp_pkg::SC_PARITY)
    else $error("parity or memory protect not prioritised");

  // dma lands on the code of its channel when nothing lower asks
  AST_DMA_SRC: assert property (@(posedge sys_clk) disable iff (!rst_b)
    take_int && dma_req && req_all[5:0] == 6'h00 && !(dma_ch2 && req_all[6])
    |-> win_code == (dma_ch2 ? ifp_pkg::SC_DMA_CH2 : ifp_pkg::SC_DMA_CH1))
    else $error("dma not prioritised");

  // the winner asks, and no lower select code does
  AST_LOWEST: assert property (@(posedge sys_clk) disable iff (!rst_b)
    take_int |-> req_all[win_code] && (req_all & ((64'h1 << win_code) - 64'h1)) == 64'h0)
    else $error("winner is not the lowest requester");

  // main scenarios
  COV_INT: cover property (@(posedge sys_clk) ph_r == ifp_pkg::IFP_PH_INT_READ && mem_ack);
  COV_MRG: cover property (@(posedge sys_clk) word_in && is_mrg);
  COV_JMP: cover property (@(posedge sys_clk) win_any && phase_end && blocked);
  COV_PF: cover property (@(posedge sys_clk) take_int && pwr_fail_req);
  COV_DMA2: cover property (@(posedge sys_clk) take_int && dma_req && dma_ch2);
endmodule : ifp_core

/* File: testbench/ifp_mem_model.sv */
// memory partner: answers trap word reads after a short wait
module ifp_mem_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // read port
  input wire logic mem_rd,
  input wire logic [14:0] mar,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_r;
  // data toggles when idle so a stale word never passes for a fresh one
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 2'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 16'hffff;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_rd && !mem_ack) begin
        wait_r <= wait_r + 2'h1;
        if (wait_r == 2'h2) begin
          wait_r <= 2'h0;
          mem_ack <= 1'b1;
          // odd codes get a word outside the memory reference group
          mem_rdata <= {mar[0] ? 6'h01 : 6'h09, mar[9:0]};
        end
      end
    end
  end
endmodule : ifp_mem_model

/* File: testbench/interrupt_fetch_phase_tb.sv */
// bench for the interrupt fetch phase sequencer
module interrupt_fetch_phase_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [63:0] io_req = 64'h0;
  logic [4:0] src = 5'h00;
  logic en = 1'b1, pfc = 1'b1, pend = 1'b0, ij = 1'b0, sj = 1'b0, done = 1'b0;
  logic mem_rd, mem_ack, ifp, pre;
  logic [15:0] rdata, ir;
  logic [14:0] pc, mar, s1;
  logic [14:0] epc = 15'h0000;
  logic [5:0] es1 = 6'h00;
  logic [2:0] phase;
  logic [5:0] ack;
  logic [4:0] sv [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h18};
  logic [5:0] ec [5] = '{6'h04, 6'h05, 6'h05, 6'h06, 6'h07};
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  ifp_core dut_u (.sys_clk, .rst_b, .io_req, .pwr_fail_req(src[0]),
    .mem_protect_req(src[1]), .parity_req(src[2]), .dma_req(src[3]),
    .dma_ch2(src[4]), .int_sys_en(en), .pwr_fail_ctl(pfc), .phase_end(pend),
    .indirect_jump(ij), .subroutine_jump(sj), .exec_done(done), .mem_rd,
    .mem_ack, .mem_rdata(rdata), .pc, .mar, .ir, .scratch1(s1), .phase,
    .interrupt_fetch_phase(ifp), .ext_preset_ind(pre), .ack_code(ack));
  ifp_mem_model mem_u (.sys_clk, .rst_b, .mem_rd, .mar, .mem_ack, .mem_rdata(rdata));
  // clock and hang guard
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      close_out;
    end
  end
  task chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error %0t %s", $time, m);
    end
  endtask : chk
  task close_out;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task pulse_end;
    @(posedge sys_clk);
    pend <= 1'b1;
    @(posedge sys_clk);
    pend <= 1'b0;
    #1;
  endtask : pulse_end
  // one full interrupt, winner c expected
  task serve(input logic [5:0] c);
    int n;
    pulse_end;
    epc = epc - 15'h0001;
    n = 0;
    chk(phase === 3'h2 && ifp === 1'b1, "no interrupt fetch");
    chk(pc === epc, "pc not decremented");
    chk(mar === {9'h000, c} && ack === c, "wrong select code");
    @(posedge sys_clk);
    #1;
    chk(phase === 3'h3 && mem_rd === 1'b1 && ifp === 1'b1, "trap read not raised");
    while (phase !== 3'h4 && n < 20) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (!c[0]) es1 = c; // only even codes get a memory reference word
    chk(ir === {c[0] ? 6'h01 : 6'h09, 4'h0, c} && mem_rd === 1'b0, "trap word");
    chk(s1 === {9'h000, es1} && phase === 3'h4, "operand or execute");
    @(posedge sys_clk);
    io_req <= 64'h0;
    src <= 5'h00;
    done <= 1'b1;
    @(posedge sys_clk);
    done <= 1'b0;
    #1;
    chk(phase === 3'h0, "no return to fetch");
  endtask : serve
  // request present but entry blocked in one of four ways
  task blocked(input int i);
    @(posedge sys_clk);
    io_req <= 64'h400;
    en <= (i != 0);
    pfc <= (i != 1);
    ij <= (i == 2);
    sj <= (i == 3);
    pulse_end;
    @(posedge sys_clk);
    #1;
    chk(phase === 3'h0 && ifp === 1'b0, "entered while blocked");
    chk(pre === (i == 1), "preset indicator");
    @(posedge sys_clk);
    {en, pfc, ij, sj} <= 4'hc;
  endtask : blocked
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) blocked(i);
    serve(6'h0a);
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      src <= sv[i];
      io_req <= 64'h400;
      serve(ec[i]);
    end
    @(posedge sys_clk);
    io_req <= 64'h0000_0000_0080_0400;
    serve(6'h0a);
    close_out;
  end
endmodule : interrupt_fetch_phase_tb
